//--- timer_b_defs.svh
// Purpose: constants for the timer_b block
// Assumes: 40 MHz clock_in
// Notes: byte indexes of the register access port
`ifndef TIMER_B_DEFS_SVH
`define TIMER_B_DEFS_SVH

`define CLOCK_PERIOD_NS 25
`define ADDR_COUNT_LOW 2'h0
`define ADDR_COUNT_HIGH 2'h1
`define ADDR_COMPARE_CAPTURE_REGISTER_LOW 2'h2
`define ADDR_COMPARE_CAPTURE_REGISTER_HIGH 2'h3
`define CLOCK_SOURCE_SELECT_SYSTEM 2'h0
`define CLOCK_SOURCE_SELECT_HALF 2'h1
`define CLOCK_SOURCE_SELECT_TIMER_A 2'h2
`define COUNT_RESET 16'h0000
`define COMPARE_CAPTURE_REGISTER_RESET 16'h0000
`define BYTE_RESET 8'h00

`endif

//--- timer_b_pkg.sv
// Purpose: types for the timer_b block
// Assumes: nothing beyond the defs header
// Notes: counter modes follow the counter_mode_field codes
`default_nettype none
package timer_b_pkg;
	typedef enum logic [2:0]
	{
		MODE_PERIODIC = 3'h0,
		MODE_TIMEOUT = 3'h1,
		MODE_CAPTURE = 3'h2,
		MODE_FREQ = 3'h3,
		MODE_PULSE_WIDTH = 3'h4,
		MODE_FREQ_PULSE = 3'h5,
		MODE_SINGLE_SHOT = 3'h6,
		MODE_PWM8 = 3'h7
	} counter_mode_t;

	typedef enum logic [0:0]
	{
		ST_RUN = 1'b0,
		ST_FROZEN = 1'b1
	} freeze_state_t;

	typedef struct packed
	{
		logic read;
		logic write;
		logic [1:0] addr;
		logic [7:0] wdata;
	} access_t;
endpackage
`default_nettype wire

//--- timer_b.sv
// Purpose: timer_b counter with its known deviations
// Assumes: event_in is asynchronous, all other inputs on clock_in
// Notes: byte access port replaces the processor register bus
// Functional notes
// - events shorter than one source tick missed in timeout, freq, pulse-width and freq-pulse modes
// - capture flag cleared by high byte read
// - freq-pulse mode freezes with prescaled clock
// - sync update restarts only on overflow
// - pwm8 mode couples bytes as 16-bit
`include "timer_b_defs.svh"
`default_nettype none
module timer_b
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire timer_b_pkg::counter_mode_t counter_mode_field_in,
	input wire logic [1:0] clock_source_select_in,
	input wire logic synchronous_update_mode_in,
	input wire logic timer_a_tick_in,
	input wire logic timer_a_restart_in,
	input wire logic timer_a_overflow_in,
	input wire logic event_in,
	input wire timer_b_pkg::access_t access_in,
	output logic [7:0] read_data_out,
	output logic capture_flag_out,
	output logic pwm_out,
	output logic frozen_out,
	output logic restart_ignored_out
);
	import timer_b_pkg::*;

	logic ev_meta, ev_sync, ev_prev, ev_sample, div;
	logic [15:0] count, compare_capture_register;
	logic [7:0] temp, read_data;
	logic flag, running, pwm, ignored;
	freeze_state_t state;
	logic next_ev_prev, next_ev_sample, next_div, next_flag, next_running, next_pwm;
	logic next_ignored;
	logic [15:0] next_count, next_compare_capture_register;
	logic [7:0] next_temp, next_read_data;
	freeze_state_t next_state;
	logic tick, raw_rise, raw_fall, q_rise, q_fall, rise, fall, capture_set, pwm8;
	logic is_rd, is_wr;

	function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
		pick_byte = hi ? w[15:8] : w[7:0];
	endfunction

	// event pin synchroniser
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			ev_meta <= 1'b0;
			ev_sync <= 1'b0;
		end
		else
		begin
			ev_meta <= event_in;
			ev_sync <= ev_meta;
		end
	end

	always_comb
	begin
		case (clock_source_select_in)
			`CLOCK_SOURCE_SELECT_SYSTEM: tick = 1'b1;
			`CLOCK_SOURCE_SELECT_TIMER_A: tick = timer_a_tick_in;
			default: tick = div;
		endcase
		pwm8 = (counter_mode_field_in == MODE_PWM8);
		is_rd = access_in.read;
		is_wr = access_in.write;
		raw_rise = ev_sync && !ev_prev;
		raw_fall = !ev_sync && ev_prev;
		q_rise = tick && ev_sync && !ev_sample;
		q_fall = tick && !ev_sync && ev_sample;
		case (counter_mode_field_in)
			MODE_TIMEOUT, MODE_FREQ, MODE_PULSE_WIDTH, MODE_FREQ_PULSE:
			begin
				rise = q_rise;
				fall = q_fall;
			end
			default:
			begin
				rise = raw_rise;
				fall = raw_fall;
			end
		endcase
	end

	always_comb
	begin
		next_ev_prev = ev_sync;
		next_ev_sample = tick ? ev_sync : ev_sample;
		next_div = !div;
		next_count = count;
		next_compare_capture_register = compare_capture_register;
		next_temp = temp;
		next_running = running;
		next_pwm = pwm;
		next_state = state;
		next_read_data = read_data;
		next_ignored = synchronous_update_mode_in && timer_a_restart_in;
		capture_set = 1'b0;
		if (!enable_in)
		begin
			next_state = ST_RUN;
			next_running = 1'b0;
			next_pwm = 1'b0;
		end
		else if (state == ST_RUN)
		begin
			if (counter_mode_field_in == MODE_FREQ_PULSE
				&& clock_source_select_in != `CLOCK_SOURCE_SELECT_SYSTEM && (raw_rise || raw_fall) && !tick)
			begin
				next_state = ST_FROZEN;
			end
			case (counter_mode_field_in)
				MODE_PERIODIC:
				begin
					if (tick)
					begin
						next_count = (count == compare_capture_register) ? `COUNT_RESET : count + 16'h0001;
						capture_set = (count == compare_capture_register);
					end
				end
				MODE_TIMEOUT:
				begin
					if (rise)
					begin
						next_count = `COUNT_RESET;
						next_running = 1'b1;
					end
					else if (fall)
						next_running = 1'b0;
					else if (tick && running)
					begin
						next_count = count + 16'h0001;
						capture_set = (count == compare_capture_register);
					end
				end
				MODE_CAPTURE:
				begin
					if (tick)
						next_count = count + 16'h0001;
					if (rise)
					begin
						next_compare_capture_register = count;
						capture_set = 1'b1;
					end
				end
				MODE_FREQ:
				begin
					if (rise)
					begin
						next_compare_capture_register = count;
						next_count = `COUNT_RESET;
						capture_set = 1'b1;
					end
					else if (tick)
						next_count = count + 16'h0001;
				end
				MODE_PULSE_WIDTH, MODE_FREQ_PULSE:
				begin
					if (rise)
						next_count = `COUNT_RESET;
					else if (fall)
					begin
						next_compare_capture_register = count;
						capture_set = 1'b1;
					end
					else if (tick)
						next_count = count + 16'h0001;
				end
				MODE_SINGLE_SHOT:
				begin
					if (rise && !running)
					begin
						next_count = `COUNT_RESET;
						next_running = 1'b1;
					end
					else if (tick && running)
					begin
						next_count = count + 16'h0001;
						next_running = (count != compare_capture_register);
						capture_set = (count == compare_capture_register);
					end
					next_pwm = running;
				end
				default:
				begin
					if (tick)
					begin
						next_count[7:0] = (count[7:0] == compare_capture_register[7:0]) ? 8'h00 : count[7:0] + 8'h01;
						capture_set = (count[7:0] == compare_capture_register[7:0]);
					end
					next_pwm = (count[7:0] < compare_capture_register[15:8]);
				end
			endcase
			// only overflow restarts in sync mode
			if (synchronous_update_mode_in && timer_a_overflow_in)
				next_count = `COUNT_RESET;
		end
		if (is_rd)
		begin
			// low read latches high into temp
			if (pwm8 && !access_in.addr[0])
			begin
				next_temp = pick_byte(access_in.addr[1] ? compare_capture_register : count, 1'b1);
				next_read_data = pick_byte(access_in.addr[1] ? compare_capture_register : count, 1'b0);
			end
			else if (pwm8)
				next_read_data = temp;
			else
				next_read_data = pick_byte(access_in.addr[1] ? compare_capture_register : count, access_in.addr[0]);
		end
		else if (is_wr)
		begin
			if (pwm8 && !access_in.addr[0])
				next_temp = access_in.wdata;
			else if (pwm8 && access_in.addr[1])
				next_compare_capture_register = {access_in.wdata, temp};
			else if (pwm8)
				next_count = {access_in.wdata, temp};
			else if (access_in.addr == `ADDR_COUNT_LOW)
				next_count[7:0] = access_in.wdata;
			else if (access_in.addr == `ADDR_COUNT_HIGH)
				next_count[15:8] = access_in.wdata;
			else if (access_in.addr == `ADDR_COMPARE_CAPTURE_REGISTER_LOW && !capture_set)
				next_compare_capture_register[7:0] = access_in.wdata;
			else if (!capture_set)
				next_compare_capture_register[15:8] = access_in.wdata;
		end
		// high byte read clears, set wins
		if (capture_set)
			next_flag = 1'b1;
		else if (is_rd && access_in.addr == `ADDR_COMPARE_CAPTURE_REGISTER_HIGH)
			next_flag = 1'b0;
		else
			next_flag = flag;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			ev_prev <= 1'b0;
			ev_sample <= 1'b0;
			div <= 1'b0;
			count <= `COUNT_RESET;
			compare_capture_register <= `COMPARE_CAPTURE_REGISTER_RESET;
			temp <= `BYTE_RESET;
			read_data <= `BYTE_RESET;
			flag <= 1'b0;
			running <= 1'b0;
			pwm <= 1'b0;
			ignored <= 1'b0;
			state <= ST_RUN;
		end
		else
		begin
			ev_prev <= next_ev_prev;
			ev_sample <= next_ev_sample;
			div <= next_div;
			count <= next_count;
			compare_capture_register <= next_compare_capture_register;
			temp <= next_temp;
			read_data <= next_read_data;
			flag <= next_flag;
			running <= next_running;
			pwm <= next_pwm;
			ignored <= next_ignored;
			state <= next_state;
		end
	end

	assign read_data_out = read_data;
	assign capture_flag_out = flag;
	assign pwm_out = pwm;
	assign frozen_out = (state == ST_FROZEN);
	assign restart_ignored_out = ignored;

	a_flag_high_clear: assert property (@(posedge clock_in) disable iff (rst_in)
		(is_rd && access_in.addr == `ADDR_COMPARE_CAPTURE_REGISTER_HIGH && !capture_set) |=> !capture_flag_out)
		else $error("capture flag not cleared by high byte read");
	a_flag_low_keep: assert property (@(posedge clock_in) disable iff (rst_in)
		(flag && is_rd && access_in.addr == `ADDR_COMPARE_CAPTURE_REGISTER_LOW) |=> capture_flag_out)
		else $error("capture flag cleared by low byte read");
	a_qualified_tick: assert property (@(posedge clock_in) disable iff (rst_in)
		(counter_mode_field_in == MODE_FREQ && state == ST_RUN && enable_in && !tick
		&& !(synchronous_update_mode_in && timer_a_overflow_in) && !is_wr)
		|=> (compare_capture_register == $past(compare_capture_register)) && !$rose(flag))
		else $error("capture taken off a source tick");
	a_freeze_lock: assert property (@(posedge clock_in) disable iff (rst_in)
		(enable_in && state == ST_RUN && counter_mode_field_in == MODE_FREQ_PULSE
		&& clock_source_select_in != `CLOCK_SOURCE_SELECT_SYSTEM && (raw_rise || raw_fall) && !tick)
		|=> frozen_out ##1 (frozen_out || !$past(enable_in)))
		else $error("freeze state not entered");
	a_freeze_sel_zero: assert property (@(posedge clock_in) disable iff (rst_in)
		(!frozen_out && clock_source_select_in == `CLOCK_SOURCE_SELECT_SYSTEM) |=> !frozen_out)
		else $error("freeze with system clock selected");
	a_overflow_restart: assert property (@(posedge clock_in) disable iff (rst_in)
		(enable_in && state == ST_RUN && synchronous_update_mode_in && timer_a_overflow_in
		&& !is_wr) |=> count == `COUNT_RESET)
		else $error("overflow did not restart counter");
	a_restart_ignored: assert property (@(posedge clock_in) disable iff (rst_in)
		(counter_mode_field_in == MODE_PERIODIC && synchronous_update_mode_in
		&& timer_a_restart_in && !timer_a_overflow_in && !tick && !is_wr)
		|=> (count == $past(count)) && restart_ignored_out)
		else $error("timer_a restart acted on counter");
	a_pwm_low_write: assert property (@(posedge clock_in) disable iff (rst_in)
		(pwm8 && is_wr && !is_rd && access_in.addr == `ADDR_COMPARE_CAPTURE_REGISTER_LOW)
		|=> (compare_capture_register == $past(compare_capture_register)) && (temp == $past(access_in.wdata)))
		else $error("pwm8 low byte written alone");
	a_pwm_high_write: assert property (@(posedge clock_in) disable iff (rst_in)
		(pwm8 && is_wr && !is_rd && access_in.addr == `ADDR_COMPARE_CAPTURE_REGISTER_HIGH)
		|=> compare_capture_register == {$past(access_in.wdata), $past(temp)})
		else $error("pwm8 word write not coupled");
endmodule // timer_b
`default_nettype wire

//--- event_source.sv
// Purpose: event system stand-in driving event_in of timer_b
// Assumes: go_in pulses on clock_in, idle level is low
// Notes: pulse length set per request
`default_nettype none
module event_source
(
	input wire logic clock_in,
	input wire logic go_in,
	input wire logic [3:0] len_in,
	output logic event_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] left = 4'h0;
	always @(posedge clock_in)
	begin
		if (go_in)
			left <= len_in;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
	assign event_out = (left != 4'h0);
endmodule // event_source
`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench for timer_b
// Assumes: 40 MHz clock_in, synchronous reset
// Notes: read results checked from a queue of expected bytes
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import timer_b_pkg::*;
	logic clock_in = 0, rst_in = 1, enable_in = 0, sync = 0, tick = 0;
	logic restart = 0, ovf = 0, go = 0, rd_d = 0, ev, flag, frozen, ign, pwm;
	counter_mode_t mode = MODE_PERIODIC;
	logic [1:0] sel = 2'h0;
	access_t acc = '0;
	logic [3:0] len = 4'h1;
	logic [7:0] rdata, r1, r2;
	logic [8:0] e;
	logic [31:0] lfsr = 32'hF3E5;
	logic [8:0] exp_q[$];
	int failures = 0, samples_checked = 0, cycles = 0;
	timer_b DUT (.clock_in(clock_in), .rst_in(rst_in), .enable_in(enable_in),
		.counter_mode_field_in(mode), .clock_source_select_in(sel),
		.synchronous_update_mode_in(sync), .timer_a_tick_in(tick),
		.timer_a_restart_in(restart), .timer_a_overflow_in(ovf), .event_in(ev),
		.access_in(acc), .read_data_out(rdata), .capture_flag_out(flag),
		.pwm_out(pwm), .frozen_out(frozen), .restart_ignored_out(ign));
	event_source src (.clock_in(clock_in), .go_in(go), .len_in(len), .event_out(ev));
	always #12.5 clock_in = ~clock_in;
	function automatic logic [31:0] next_lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
		samples_checked++;
		if (got !== want)
		begin
			failures++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic check_bit(input logic got, input logic want, input string what);
		samples_checked++;
		if (got !== want)
		begin
			failures++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	// one access, read expectation noted with care bit
	task automatic acc_op(input logic rd, input logic [1:0] a, input logic [7:0] d,
		input logic [8:0] ex);
		@(posedge clock_in);
		acc <= '{rd, !rd, a, d};
		if (rd)
			exp_q.push_back(ex);
		@(posedge clock_in);
		acc <= '0;
	endtask
	task automatic pulse_ev(input logic [3:0] n);
		len <= n;
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
	endtask
	always @(posedge clock_in)
	begin
		cycles++;
		rd_d <= acc.read;
		if (rd_d)
		begin
			e = exp_q.pop_front();
			if (e[8])
				check(rdata, e[7:0], "read byte");
		end
		if (cycles == 3000)
		begin
			failures++;
			stop_test();
		end
	end
	initial
	begin
		cyc(16);
		rst_in <= 1'b0;
		enable_in <= 1'b1;
		mode <= MODE_PWM8;
		lfsr = next_lfsr(next_lfsr(lfsr));
		// compare high above low keeps pwm8 output high
		r1 = {1'b0, lfsr[6:0]};
		r2 = {1'b1, lfsr[14:8]};
		acc_op(1'b1, 2'h2, 8'h00, 9'h100);
		acc_op(1'b0, 2'h2, r1, 9'h000);
		acc_op(1'b0, 2'h3, r2, 9'h000);
		acc_op(1'b1, 2'h2, 8'h00, {1'b1, r1});
		acc_op(1'b1, 2'h3, 8'h00, {1'b1, r2});
		check_bit(pwm, 1'b1, "pwm8 threshold not coupled");
		$display("test pwm8 done");
		mode <= MODE_FREQ;
		acc_op(1'b1, 2'h3, 8'h00, {1'b1, r2});
		cyc(1);
		check_bit(flag, 1'b0, "flag left from pwm8");
		pulse_ev(4'h4);
		for (int i = 0; i < 12 && flag !== 1'b1; i++)
			cyc(1);
		check_bit(flag, 1'b1, "flag not set");
		acc_op(1'b1, 2'h2, 8'h00, 9'h000);
		cyc(1);
		check_bit(flag, 1'b1, "flag lost on low read");
		acc_op(1'b1, 2'h3, 8'h00, 9'h000);
		cyc(1);
		check_bit(flag, 1'b0, "flag kept on high read");
		sel <= 2'h2;
		pulse_ev(4'h1);
		cyc(8);
		check_bit(flag, 1'b0, "short event seen");
		// long event spans a source tick
		pulse_ev(4'h8);
		cyc(4);
		tick <= 1'b1;
		cyc(1);
		tick <= 1'b0;
		cyc(2);
		check_bit(flag, 1'b1, "long event lost");
		$display("test capture done");
		mode <= MODE_PERIODIC;
		sync <= 1'b1;
		acc_op(1'b0, 2'h0, 8'h5A, 9'h000);
		restart <= 1'b1;
		cyc(1);
		restart <= 1'b0;
		for (int i = 0; i < 4 && ign !== 1'b1; i++)
			cyc(1);
		check_bit(ign, 1'b1, "restart not flagged");
		acc_op(1'b1, 2'h0, 8'h00, 9'h15A);
		ovf <= 1'b1;
		cyc(1);
		ovf <= 1'b0;
		acc_op(1'b1, 2'h0, 8'h00, 9'h100);
		$display("test sync done");
		sync <= 1'b0;
		mode <= MODE_FREQ_PULSE;
		sel <= 2'h1;
		cyc(1);
		pulse_ev(4'h1);
		for (int i = 0; i < 10 && frozen !== 1'b1; i++)
			cyc(1);
		check_bit(frozen, 1'b1, "no freeze");
		enable_in <= 1'b0;
		cyc(3);
		check_bit(frozen, 1'b0, "freeze kept");
		sel <= 2'h0;
		cyc(2);
		$display("test freeze done");
		stop_test();
	end
endmodule // tb
`default_nettype wire
